//--- src/pfc_regs.vh
// Purpose: constants for the parallel flash host controller
// Assumes: byte-wide flash, 40 MHz core clock
// Notes: command addresses use the low 15 address bits
`ifndef PFC_REGS_VH
`define PFC_REGS_VH
`define PFC_ADDR_UNLOCK1 15'h5555
`define PFC_ADDR_UNLOCK2 15'h2AAA
`define PFC_CODE_UNLOCK1 8'hAA
`define PFC_CODE_UNLOCK2 8'h55
`define PFC_CODE_PROGRAM 8'hA0
`define PFC_CODE_ERASE 8'h80
`define PFC_CODE_SECTOR 8'h30
`define PFC_CODE_CHIP 8'h10
`define PFC_CODE_ID_ENTRY 8'h90
`define PFC_CODE_ID_EXIT 8'hF0
`define PFC_ID_MAKER_ADDR 18'h0_0000
`define PFC_ID_PART_ADDR 18'h0_0001
`define PFC_OP_READ 3'h0
`define PFC_OP_PROGRAM 3'h1
`define PFC_OP_SECTOR 3'h2
`define PFC_OP_CHIP 3'h3
`define PFC_OP_ID_ENTRY 3'h4
`define PFC_OP_ID_EXIT 3'h5
`define PFC_OP_ID_EXIT_SHORT 3'h6
`define PFC_OP_READ_ID 3'h7
// bus phase timing in ns; read cycle time of the slow grade
`define PFC_T_SETUP_NS 25
`define PFC_T_STROBE_NS 75
`define PFC_T_READ_NS 100
`define PFC_T_HOLD_NS 50
`define PFC_T_PROGRAM_US 30
`define PFC_CLK_MHZ 40
`define PFC_RETRIES 2
`endif

//--- src/pfc_bus_cycle.v
// Purpose: one strobed read or write cycle on the flash pins
// Assumes: host drives all strobes, flash is only a data source
// Notes: write data is released only after the write strobe has risen
`timescale 1ns/10ps
`default_nettype none
`include "pfc_regs.vh"
module pfc_bus_cycle #(
    parameter ADDR_W = 18,
    parameter SETUP_CYC = 1,
    parameter STROBE_CYC = 3,
    parameter READ_CYC = 4,
    parameter HOLD_CYC = 2
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // request
    input wire start,
    input wire isWrite,
    input wire [ADDR_W-1:0] addr,
    input wire [7:0] wrData,
    output wire busy,
    output reg done,
    output reg [7:0] rdData_q,
    // flash pins
    output reg [ADDR_W-1:0] flashAddr_q,
    output reg chipSelect_n_q,
    output reg outputGate_n_q,
    output reg writeStrobe_n_q,
    output reg [7:0] dqOut_q,
    output reg dqOe_q,
    input wire [7:0] dqIn
);
    localparam S_IDLE = 4'b0001;
    localparam S_SETUP = 4'b0010;
    localparam S_STROBE = 4'b0100;
    localparam S_HOLD = 4'b1000;
    reg [3:0] state_q;
    reg [7:0] cnt_q;
    reg wr_q;
    reg [7:0] dqSync1_q;
    reg [7:0] dqSync2_q;
    assign busy = (state_q != S_IDLE);
    // pins from outside: two flops before use
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dqSync1_q <= 8'h00;
            dqSync2_q <= 8'h00;
        end else begin
            dqSync1_q <= dqIn;
            dqSync2_q <= dqSync1_q;
        end
    end
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            done <= 1'b0;
            rdData_q <= 8'h00;
            flashAddr_q <= {ADDR_W{1'b0}};
            chipSelect_n_q <= 1'b1;
            outputGate_n_q <= 1'b1;
            writeStrobe_n_q <= 1'b1;
            dqOut_q <= 8'h00;
            dqOe_q <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        flashAddr_q <= addr;
                        wr_q <= isWrite;
                        dqOut_q <= wrData;
                        chipSelect_n_q <= 1'b0;
                        outputGate_n_q <= 1'b1;
                        dqOe_q <= isWrite;
                        cnt_q <= SETUP_CYC[7:0];
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_q <= 8'h01) begin
                        writeStrobe_n_q <= ~wr_q;
                        outputGate_n_q <= wr_q;
                        cnt_q <= wr_q ? STROBE_CYC[7:0] : READ_CYC[7:0];
                        state_q <= S_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                S_STROBE: begin
                    if (cnt_q <= 8'h01) begin
                        writeStrobe_n_q <= 1'b1;
                        outputGate_n_q <= 1'b1;
                        if (!wr_q) begin
                            rdData_q <= dqSync2_q;
                        end
                        cnt_q <= HOLD_CYC[7:0];
                        state_q <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                S_HOLD: begin
                    if (cnt_q <= 8'h01) begin
                        chipSelect_n_q <= 1'b1;
                        dqOe_q <= 1'b0;
                        done <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- src/pfc_host.v
// Purpose: host sequencer issuing unlock command sequences to a parallel flash
// Assumes: one command at a time, requested by a pulse on cmdStart
// Notes: completion found by the alternating status bit, confirmed by rereads
//
// Notes on behaviour
// - host writes each cycle with write strobe low under chip select.
// - program is three unlock cycles plus address and data cycle.
// - sector erase: six cycles, last carries sector address and 30H.
// - chip erase: six cycles ending 10H at 5555H.
// - on inconsistent status, reread twice; done only if both valid.
// - identification mode lasts until an exit sequence.
// - unlock prefix AAH@5555H, 55H@2AAAH, then operation code.
// - identification entry 90H; exit F0H single or with prefix.
`timescale 1ns/10ps
`default_nettype none
`include "pfc_regs.vh"
module pfc_host #(
    parameter ADDR_W = 18,
    parameter POLL_LIMIT = 2000
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // command port
    input wire cmdStart,
    input wire [2:0] cmdOp,
    input wire [ADDR_W-1:0] cmdAddr,
    input wire [7:0] cmdData,
    output wire cmdReady,
    output reg cmdDone_q,
    output reg cmdError_q,
    output reg [7:0] rdData_q,
    output reg idMode_q,
    // flash pins
    output wire [ADDR_W-1:0] flashAddr,
    output wire chipSelect_n,
    output wire outputGate_n,
    output wire writeStrobe_n,
    output wire [7:0] dqOut,
    output wire dqOe,
    input wire [7:0] dqIn
);
    localparam integer CLK_NS = 1000 / `PFC_CLK_MHZ;
    // least times round up
    localparam integer SETUP_CYC = (`PFC_T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam integer STROBE_CYC = (`PFC_T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam integer READ_CYC = (`PFC_T_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam integer HOLD_CYC = (`PFC_T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam S_IDLE = 5'b00001;
    localparam S_WRITE = 5'b00010;
    localparam S_READ = 5'b00100;
    localparam S_POLL = 5'b01000;
    localparam S_FINISH = 5'b10000;
    reg [4:0] state_q;
    reg [2:0] op_q;
    reg [ADDR_W-1:0] addr_q;
    reg [7:0] data_q;
    reg [2:0] step_q;
    reg [2:0] nSteps_q;
    reg havePrev_q;
    reg [7:0] prev_q;
    reg [1:0] stable_q;
    reg [15:0] polls_q;
    reg busStart;
    reg busWrite;
    reg [ADDR_W-1:0] busAddr;
    reg [7:0] busData;
    wire busBusy;
    wire busDone;
    wire [7:0] busRd;
    // address and data of cycle k of a command sequence
    function [ADDR_W+7:0] seqCycle;
        input [2:0] op;
        input [2:0] k;
        input [ADDR_W-1:0] a;
        input [7:0] d;
        reg [7:0] code;
        begin
            code = `PFC_CODE_ID_EXIT;
            if (op == `PFC_OP_PROGRAM) code = `PFC_CODE_PROGRAM;
            if (op == `PFC_OP_SECTOR || op == `PFC_OP_CHIP) code = `PFC_CODE_ERASE;
            if (op == `PFC_OP_ID_ENTRY) code = `PFC_CODE_ID_ENTRY;
            case (k)
                3'd0, 3'd3: seqCycle = {{(ADDR_W-15){1'b0}}, `PFC_ADDR_UNLOCK1,
                    `PFC_CODE_UNLOCK1};
                3'd1, 3'd4: seqCycle = {{(ADDR_W-15){1'b0}}, `PFC_ADDR_UNLOCK2,
                    `PFC_CODE_UNLOCK2};
                3'd2: seqCycle = {{(ADDR_W-15){1'b0}}, `PFC_ADDR_UNLOCK1, code};
                default: seqCycle = {a, d};
            endcase
            if (k == 3'd3 && op == `PFC_OP_PROGRAM) seqCycle = {a, d};
            if (k == 3'd5 && op == `PFC_OP_SECTOR) seqCycle = {a, `PFC_CODE_SECTOR};
            if (k == 3'd5 && op == `PFC_OP_CHIP) seqCycle = {{(ADDR_W-15){1'b0}},
                `PFC_ADDR_UNLOCK1, `PFC_CODE_CHIP};
            if (op == `PFC_OP_ID_EXIT_SHORT) seqCycle = {a, `PFC_CODE_ID_EXIT};
        end
    endfunction
    wire [ADDR_W+7:0] cyc = seqCycle(op_q, step_q, addr_q, data_q);
    wire isDirectRead = (cmdOp == `PFC_OP_READ) || (cmdOp == `PFC_OP_READ_ID);
    assign cmdReady = (state_q == S_IDLE);
    always @* begin
        busStart = 1'b0;
        busWrite = 1'b0;
        busAddr = addr_q;
        busData = data_q;
        if (!busBusy && !busDone) begin
            if (state_q == S_WRITE) begin
                busStart = 1'b1;
                busWrite = 1'b1;
                busAddr = cyc[ADDR_W+7:8];
                busData = cyc[7:0];
            end else if (state_q == S_READ || state_q == S_POLL) begin
                busStart = 1'b1;
            end
        end
    end
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            op_q <= `PFC_OP_READ;
            addr_q <= {ADDR_W{1'b0}};
            data_q <= 8'h00;
            step_q <= 3'd0;
            nSteps_q <= 3'd0;
            havePrev_q <= 1'b0;
            prev_q <= 8'h00;
            stable_q <= 2'd0;
            polls_q <= 16'h0000;
            cmdDone_q <= 1'b0;
            cmdError_q <= 1'b0;
            rdData_q <= 8'h00;
            idMode_q <= 1'b0;
        end else begin
            cmdDone_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (cmdStart) begin
                        op_q <= cmdOp;
                        addr_q <= cmdAddr;
                        data_q <= cmdData;
                        cmdError_q <= 1'b0;
                        step_q <= 3'd0;
                        havePrev_q <= 1'b0;
                        stable_q <= 2'd0;
                        polls_q <= 16'h0000;
                        case (cmdOp)
                            `PFC_OP_PROGRAM: nSteps_q <= 3'd4;
                            `PFC_OP_SECTOR, `PFC_OP_CHIP: nSteps_q <= 3'd6;
                            `PFC_OP_ID_EXIT_SHORT: nSteps_q <= 3'd1;
                            default: nSteps_q <= 3'd3;
                        endcase
                        state_q <= isDirectRead ? S_READ : S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (busDone) begin
                        if (step_q == nSteps_q - 3'd1) begin
                            if (op_q == `PFC_OP_PROGRAM || op_q == `PFC_OP_SECTOR ||
                                op_q == `PFC_OP_CHIP) begin
                                state_q <= S_POLL;
                            end else begin
                                idMode_q <= (op_q == `PFC_OP_ID_ENTRY);
                                state_q <= S_FINISH;
                            end
                        end else begin
                            step_q <= step_q + 3'd1;
                        end
                    end
                end
                S_READ: begin
                    if (busDone) begin
                        rdData_q <= busRd;
                        state_q <= S_FINISH;
                    end
                end
                S_POLL: begin
                    if (busDone) begin
                        rdData_q <= busRd;
                        havePrev_q <= 1'b1;
                        prev_q <= busRd;
                        polls_q <= polls_q + 16'h0001;
                        if (havePrev_q && prev_q[6] == busRd[6]) begin
                            if (stable_q == `PFC_RETRIES - 1) begin
                                state_q <= S_FINISH;
                            end
                            stable_q <= stable_q + 2'd1;
                        end else begin
                            stable_q <= 2'd0;
                        end
                        if (polls_q == POLL_LIMIT[15:0]) begin
                            cmdError_q <= 1'b1;
                            state_q <= S_FINISH;
                        end
                    end
                end
                S_FINISH: begin
                    cmdDone_q <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
    pfc_bus_cycle #(
        .ADDR_W(ADDR_W),
        .SETUP_CYC(SETUP_CYC),
        .STROBE_CYC(STROBE_CYC),
        .READ_CYC(READ_CYC),
        .HOLD_CYC(HOLD_CYC)
    ) u_bus (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(busStart),
        .isWrite(busWrite),
        .addr(busAddr),
        .wrData(busData),
        .busy(busBusy),
        .done(busDone),
        .rdData_q(busRd),
        .flashAddr_q(flashAddr),
        .chipSelect_n_q(chipSelect_n),
        .outputGate_n_q(outputGate_n),
        .writeStrobe_n_q(writeStrobe_n),
        .dqOut_q(dqOut),
        .dqOe_q(dqOe),
        .dqIn(dqIn)
    );
endmodule
`default_nettype wire

//--- test/pfc_flash_model.sv
// Purpose: behavioural byte-wide flash for the host sequencer bench
// Assumes: write-strobe controlled writes, 256-byte aliased array
// Notes: hang keeps status reads busy to force a host poll timeout
`timescale 1ns/10ps
`default_nettype none
module pfc_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h5A, // arbitrary value
    parameter int BUSY_NS = 2000
) (
    // flash pins
    input wire logic [17:0] flashAddr,
    input wire logic chipSelect_n,
    input wire logic outputGate_n,
    input wire logic writeStrobe_n,
    input wire logic [7:0] dqOut,
    input wire logic dqOe,
    output logic [7:0] dqIn,
    // fault control
    input wire logic hang
);
    logic [7:0] mem [0:255];
    logic [17:0] latA;
    logic [7:0] prog, held, rdVal;
    logic [2:0] step;
    logic idMode, busyQ, erasing, tog;
    wire busy = busyQ | hang;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        {step, idMode, busyQ, erasing, tog, held, prog, latA} = '0;
    end
    always_comb begin
        if (busy) rdVal = {erasing ? 1'b0 : ~prog[7], tog, 6'h00};
        else if (idMode && flashAddr[17:1] == 17'h0_0000) rdVal = flashAddr[0] ? PART_CODE : MAKER_CODE;
        else rdVal = mem[flashAddr[7:0]];
    end
    assign dqIn = (!chipSelect_n && !outputGate_n) ? rdVal : ~held;
    always @(posedge outputGate_n) begin
        held = rdVal;
        if (busy && !chipSelect_n) tog = ~tog;
    end
    // finishes well inside the program time
    always @(posedge busyQ) begin
        #(BUSY_NS);
        busyQ = 0;
    end
    // address on falling strobe under select
    always @(negedge writeStrobe_n) if (!chipSelect_n && outputGate_n) latA = flashAddr;
    always @(posedge writeStrobe_n) if (!chipSelect_n && outputGate_n && dqOe && !busy) cmdWrite(dqOut);
    task automatic cmdWrite(input logic [7:0] d);
        logic ok1, ok2;
        ok1 = latA[14:0] == 15'h5555 && d == 8'hAA;
        ok2 = latA[14:0] == 15'h2AAA && d == 8'h55;
        case (step)
            0: begin
                step = ok1 ? 3'h1 : 3'h0;
                if (d == 8'hF0) idMode = 0;
            end
            1, 5: step = ok2 ? step + 3'h1 : 3'h0;
            4: step = ok1 ? 3'h5 : 3'h0;
            2: begin
                step = 0;
                if (latA[14:0] == 15'h5555) begin
                    if (d == 8'hA0) step = 3;
                    if (d == 8'h80) step = 4;
                    if (d == 8'h90) idMode = 1;
                    if (d == 8'hF0) idMode = 0;
                end
            end
            3: begin
                mem[latA[7:0]] &= d;
                prog = d;
                {erasing, tog, busyQ, step} = {3'b011, 3'h0};
            end
            default: begin
                if (d == 8'h30 || (d == 8'h10 && latA[14:0] == 15'h5555)) begin
                    foreach (mem[i]) mem[i] = 8'hFF;
                    {erasing, tog, busyQ} = 3'b111;
                end
                step = 0;
            end
        endcase
    endtask
endmodule
`default_nettype wire

//--- test/pfc_host_asserts.sv
// Purpose: port-level checks of the host flash sequencer
// Assumes: single core clock, async active-low reset
// Notes: strobe widths follow the documented bus cycle walk
`timescale 1ns/10ps
`default_nettype none
module pfc_host_asserts #(
    parameter ADDR_W = 18
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // command port
    input wire cmdStart,
    input wire [2:0] cmdOp,
    input wire cmdReady,
    input wire cmdDone_q,
    // flash pins
    input wire [ADDR_W-1:0] flashAddr,
    input wire chipSelect_n,
    input wire outputGate_n,
    input wire writeStrobe_n,
    input wire [7:0] dqOut,
    input wire dqOe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_writeLow;
        !writeStrobe_n [*3];
    endsequence
    sequence s_readLow;
        !outputGate_n [*4];
    endsequence
    property p_weUnderCs;
        !writeStrobe_n |-> !chipSelect_n && outputGate_n;
    endproperty
    a_weUnderCs: assert property (p_weUnderCs) else $error("write strobe outside select");
    property p_noContention;
        !outputGate_n |-> !chipSelect_n && !dqOe;
    endproperty
    a_noContention: assert property (p_noContention) else $error("read gate while driving");
    property p_stableWrite;
        !writeStrobe_n && $past(!writeStrobe_n) |-> $stable(flashAddr) && $stable(dqOut);
    endproperty
    a_stableWrite: assert property (p_stableWrite) else $error("write bus moved");
    property p_dataHeld;
        $rose(writeStrobe_n) |-> dqOe && !chipSelect_n ##1 !chipSelect_n;
    endproperty
    a_dataHeld: assert property (p_dataHeld) else $error("data dropped at strobe rise");
    property p_wePulse;
        $fell(writeStrobe_n) |-> s_writeLow ##1 writeStrobe_n;
    endproperty
    a_wePulse: assert property (p_wePulse) else $error("write strobe width");
    property p_readPulse;
        $fell(outputGate_n) |-> s_readLow ##1 outputGate_n;
    endproperty
    a_readPulse: assert property (p_readPulse) else $error("read gate width");
    property p_oneCmd;
        cmdStart && cmdReady |=> !cmdReady;
    endproperty
    a_oneCmd: assert property (p_oneCmd) else $error("ready after take");
    property p_donePulse;
        cmdDone_q |=> !cmdDone_q;
    endproperty
    a_donePulse: assert property (p_donePulse) else $error("done longer than a cycle");
    property p_unlockFirst;
        cmdStart && cmdReady && cmdOp inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}
            |-> ##[1:12] (!writeStrobe_n && flashAddr[14:0] == 15'h5555 && dqOut == 8'hAA);
    endproperty
    a_unlockFirst: assert property (p_unlockFirst) else $error("no unlock first write");
endmodule
bind pfc_host pfc_host_asserts #(.ADDR_W(ADDR_W)) pfc_host_asserts_i (.core_clk, .rstn,
    .cmdStart, .cmdOp, .cmdReady, .cmdDone_q, .flashAddr, .chipSelect_n, .outputGate_n,
    .writeStrobe_n, .dqOut, .dqOe);
`default_nettype wire

//--- test/pfc_host_bench.sv
// Purpose: self-checking bench for the host flash sequencer
// Assumes: flash model ends program and erase after a fixed busy time
// Notes: shadow array mirrors the aliased model array
`timescale 1ns/10ps
`default_nettype none
`include "pfc_regs.vh"
module pfc_host_bench;
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
    localparam logic [7:0] PART = 8'h5A; // arbitrary value
    logic core_clk, rstn, cmdStart, hang;
    logic [2:0] cmdOp;
    logic [17:0] cmdAddr, a;
    logic [7:0] cmdData, d;
    wire cmdReady, cmdDone_q, cmdError_q, idMode_q, chipSelect_n, outputGate_n, writeStrobe_n, dqOe;
    wire [7:0] rdData_q, dqOut, dqIn;
    wire [17:0] flashAddr;
    int err_count, tests_run;
    logic [7:0] shadow [0:255];
    pfc_host #(.POLL_LIMIT(50)) pfc_host_i (.core_clk, .rstn, .cmdStart, .cmdOp, .cmdAddr,
        .cmdData, .cmdReady, .cmdDone_q, .cmdError_q, .rdData_q, .idMode_q, .flashAddr,
        .chipSelect_n, .outputGate_n, .writeStrobe_n, .dqOut, .dqOe, .dqIn);
    pfc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) pfc_flash_model_i (.flashAddr,
        .chipSelect_n, .outputGate_n, .writeStrobe_n, .dqOut, .dqOe, .dqIn, .hang);
    // ==========================================
    // tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // programming only clears bits
    function automatic logic [7:0] progResult(input logic [7:0] old, input logic [7:0] dt);
        return old & dt;
    endfunction
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic runCmd(input logic [2:0] op, input logic [17:0] ad, input logic [7:0] dt);
        int n;
        n = 0;
        @(negedge core_clk);
        while (cmdReady !== 1'b1) @(negedge core_clk);
        {cmdStart, cmdOp, cmdAddr, cmdData} = {1'b1, op, ad, dt};
        @(negedge core_clk);
        cmdStart = 0;
        while (cmdDone_q !== 1'b1 && n < 20000) begin
            n++;
            @(negedge core_clk);
        end
        if (n >= 20000) check(8'h00, 8'h01);
    endtask
    // ==========================================
    // clock, watchdog and tests
    initial begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #1500000;
        err_count++;
        stop_test();
    end
    initial begin
        {rstn, cmdStart, cmdOp, cmdAddr, cmdData, hang, err_count, tests_run} = '0;
        foreach (shadow[i]) shadow[i] = 8'hFF;
        void'($urandom(6710));
        repeat (20) @(negedge core_clk);
        rstn = 1;
        for (int k = 0; k < 2; k++) begin
            runCmd(`PFC_OP_ID_ENTRY, 18'h0_0000, 8'h00);
            check({7'h00, idMode_q}, 8'h01);
            runCmd(`PFC_OP_READ_ID, 18'h0_0000, 8'h00);
            check(rdData_q, MAKER);
            runCmd(`PFC_OP_READ_ID, 18'h0_0001, 8'h00);
            check(rdData_q, PART);
            runCmd(k ? `PFC_OP_ID_EXIT_SHORT : `PFC_OP_ID_EXIT, 18'h0_0000, 8'h00);
            check({7'h00, idMode_q}, 8'h00);
            runCmd(`PFC_OP_READ, 18'h0_0001, 8'h00);
            check(rdData_q, 8'hFF);
        end
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 18'h3_FFFF : 18'($urandom);
            d = (i == 1) ? 8'h00 : 8'($urandom);
            shadow[a[7:0]] = progResult(shadow[a[7:0]], d);
            runCmd(`PFC_OP_PROGRAM, a, d);
            check(rdData_q, shadow[a[7:0]]);
            check({7'h00, cmdError_q}, 8'h00);
            runCmd(`PFC_OP_READ, a, 8'h00);
            check(rdData_q, shadow[a[7:0]]);
        end
        runCmd(`PFC_OP_SECTOR, a, 8'h00);
        runCmd(`PFC_OP_READ, a, 8'h00);
        check(rdData_q, 8'hFF);
        runCmd(`PFC_OP_PROGRAM, 18'h0_0010, 8'h5A);
        runCmd(`PFC_OP_CHIP, 18'h0_0000, 8'h00);
        runCmd(`PFC_OP_READ, 18'h0_0010, 8'h00);
        check(rdData_q, 8'hFF);
        // status never settles, host must give up; the program write is dropped as busy
        hang = 1;
        runCmd(`PFC_OP_PROGRAM, 18'h0_0020, 8'h0F);
        check({7'h00, cmdError_q}, 8'h01);
        hang = 0;
        runCmd(`PFC_OP_READ, 18'h0_0020, 8'h00);
        check(rdData_q, 8'hFF);
        check({7'h00, cmdError_q}, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
